// File: sptx_params.svh
// Offsets, field positions, reset values and timing counts of the S/PDIF transmitter control.
`ifndef SPTX_PARAMS_SVH
`define SPTX_PARAMS_SVH
`define SPTX_OFF_CONTROL 8'h3C
`define SPTX_OFF_CONFIG 8'h40
`define SPTX_OFF_STATUS 8'h44
`define SPTX_BIT_VALIDITY 15
`define SPTX_RATE_HI 14
`define SPTX_RATE_LO 12
`define SPTX_BIT_GEN 11
`define SPTX_CAT_HI 10
`define SPTX_CAT_LO 4
`define SPTX_BIT_EMPH 3
`define SPTX_BIT_COPY 2
`define SPTX_BIT_NONAUDIO 1
`define SPTX_BIT_PRO 0
`define SPTX_CFG_BIT_ENABLE 7
`define SPTX_CFG_BIT_SLAVE 8
`define SPTX_RESET_FITTED 16'h2000
`define SPTX_RESET_ABSENT 16'h0000
`define SPTX_BLOCK_FRAMES 8'd192
`define SPTX_SYNC_FILL 2'd3
`define SPTX_RESP_OKAY 2'b00
`define SPTX_RESP_SLVERR 2'b10
`endif

// File: sptx_pkg.sv
// Types shared by the S/PDIF transmitter control files.
package sptx_pkg;
   // Phase of the strap capture after reset.
   typedef enum logic [1:0] {ST_WAIT, ST_SAMPLE, ST_RUN} sptx_strap_t;
endpackage : sptx_pkg

// File: sptx_cs_mux.sv
// Channel-status bit selector for one frame of a 192-frame block.
`timescale 1ns/1ps
`include "sptx_params.svh"
module sptx_cs_mux (
   // Control register image.
   input wire logic [15:0] ctrl,
   // Frame index within the block.
   input wire logic [7:0] frame,
   // Selected channel status bit.
   output logic cs_bit
);
   // Byte and bit position of the current frame.
   logic [4:0] byte_idx;
   logic [2:0] bit_idx;
   logic [7:0] cs_byte;
   logic [2:0] rate;
   assign byte_idx = frame[7:3];
   assign bit_idx = frame[2:0];
   assign rate = ctrl[`SPTX_RATE_HI:`SPTX_RATE_LO];

   // Builds the channel status byte for the current frame.
   always_comb
   begin
      cs_byte = 8'h00;
      if (ctrl[`SPTX_BIT_PRO])
      begin
         // Professional layout: rate in byte 0 bits 7-6 and byte 4 bits 5-3.
         case (byte_idx)
            5'd0: cs_byte = {rate[1:0], 3'b000, ctrl[`SPTX_BIT_EMPH], ctrl[`SPTX_BIT_NONAUDIO],
                             1'b1};
            5'd4: cs_byte = {1'b0, 1'b0, rate, 3'b000};
            default: cs_byte = 8'h00;
         endcase
      end
      else
      begin
         // Consumer layout: flags, category, generation and rate nibble.
         case (byte_idx)
            5'd0: cs_byte = {4'h0, 1'b0, ctrl[`SPTX_BIT_EMPH], ctrl[`SPTX_BIT_COPY],
                             ctrl[`SPTX_BIT_NONAUDIO]} << 1;
            5'd1: cs_byte = {ctrl[`SPTX_BIT_GEN], ctrl[`SPTX_CAT_HI:`SPTX_CAT_LO]};
            5'd3: cs_byte = {4'h0, 1'b0, rate};
            default: cs_byte = 8'h00;
         endcase
      end
   end

   // Bit 0 of each byte goes first.
   assign cs_bit = cs_byte[bit_idx];
endmodule : sptx_cs_mux

// File: sptx_control.sv
// S/PDIF transmitter control register with AXI4-Lite slave and channel status sequencer.
`timescale 1ns/1ps
`include "sptx_params.svh"
module sptx_control (
   // Clock, reset and clock enable.
   input wire logic clock,
   input wire logic rst,
   input wire logic clk_en,
   // AXI4-Lite write address channel.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data channel.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address channel.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Strap pin, low when the transmitter is fitted.
   input wire logic transmitter_present_strap,
   // Low nibble of the master sample-rate selection register.
   input wire logic [3:0] master_rate_select,
   // Frame strobe from the serialiser, one pulse per frame.
   input wire logic frame_tick,
   // Per-frame outputs to the serialiser.
   output logic validity_bit,
   output logic cs_bit,
   output logic block_start,
   // Transmitter enable from the configuration register, forced low while the transmitter is not fitted.
   output logic tx_enable
);
   //////////////////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser and capture.
   //////////////////////////////////////////////////////////////////////////////////////////

   // Three-stage synchroniser for the strap pin.
   logic strap_s1_r;
   logic strap_s2_r;
   logic strap_s3_r;
   // Captured fitted flag.
   logic fitted_r;
   // Capture sequence state.
   sptx_pkg::sptx_strap_t strap_st_r;
   sptx_pkg::sptx_strap_t strap_st_nxt;
   // Enabled clocks since reset, saturating once the synchroniser is full.
   logic [1:0] fill_r;

   // Shifts the strap through three flip-flops.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         strap_s1_r <= 1'b1;
         strap_s2_r <= 1'b1;
         strap_s3_r <= 1'b1;
      end
      else if (clk_en)
      begin
         strap_s1_r <= transmitter_present_strap;
         strap_s2_r <= strap_s1_r;
         strap_s3_r <= strap_s2_r;
      end
   end

   // Waits for the synchroniser to fill, then samples once stages two and three agree.
   always_comb
   begin
      strap_st_nxt = strap_st_r;
      case (strap_st_r)
         sptx_pkg::ST_WAIT:
         begin
            // Stages still holding their reset value would pass for an absent transmitter.
            if (fill_r == `SPTX_SYNC_FILL)
            begin
               strap_st_nxt = sptx_pkg::ST_SAMPLE;
            end
         end
         sptx_pkg::ST_SAMPLE:
         begin
            // Only a settled value is taken.
            if (strap_s2_r == strap_s3_r)
            begin
               strap_st_nxt = sptx_pkg::ST_RUN;
            end
         end
         sptx_pkg::ST_RUN: strap_st_nxt = sptx_pkg::ST_RUN;
         default: strap_st_nxt = sptx_pkg::ST_WAIT;
      endcase
   end

   // Holds the capture state.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         strap_st_r <= sptx_pkg::ST_WAIT;
         fill_r <= 2'd0;
      end
      else if (clk_en)
      begin
         strap_st_r <= strap_st_nxt;
         // Counts until the pin has reached the third stage.
         if (fill_r != `SPTX_SYNC_FILL)
         begin
            fill_r <= fill_r + 2'd1;
         end
      end
   end

   // Latches the fitted flag; a low strap means fitted.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fitted_r <= 1'b0;
      end
      else if (clk_en && strap_st_r == sptx_pkg::ST_SAMPLE && strap_s2_r == strap_s3_r)
      begin
         fitted_r <= ~strap_s3_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path.
   //////////////////////////////////////////////////////////////////////////////////////////

   // Held write address and data.
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic do_write;
   logic [31:0] ctrl_wr;
   // Register storage.
   logic [15:0] ctrl_r;
   logic [31:0] cfg_r;
   // Set once the control register has been loaded after the strap capture.
   logic ctrl_init_r;

   assign s_axi_awready = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready = ~w_held_r & ~bvalid_r;
   assign do_write = aw_held_r & w_held_r & ~bvalid_r;

   // Decodes an offset to whether it is mapped.
   function automatic logic sptx_mapped(input logic [7:0] a);
      sptx_mapped = (a == `SPTX_OFF_CONTROL) || (a == `SPTX_OFF_CONFIG) ||
                    (a == `SPTX_OFF_STATUS);
   endfunction : sptx_mapped

   // Merges byte lanes of a write into an old word.
   function automatic logic [31:0] sptx_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
      begin
         sptx_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
   endfunction : sptx_merge

   // Control word with the held write merged in; only the low half is stored.
   assign ctrl_wr = sptx_merge({16'h0000, ctrl_r}, wdata_r, wstrb_r);

   // Captures the address and data in either order.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
         end
         else if (do_write)
         begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (do_write)
         begin
            w_held_r <= 1'b0;
         end
      end
   end

   // Issues the write response after both halves are held.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= `SPTX_RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (do_write)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= sptx_mapped(awaddr_r) ? `SPTX_RESP_OKAY : `SPTX_RESP_SLVERR;
         end
         else if (s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Control and configuration registers.
   //////////////////////////////////////////////////////////////////////////////////////////

   // Loads the power-up value once the strap is known, then takes writes and master rate while fitted.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= `SPTX_RESET_ABSENT;
         ctrl_init_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!ctrl_init_r)
         begin
            // Wait for the strap to settle before choosing the power-up value.
            if (strap_st_r == sptx_pkg::ST_RUN)
            begin
               ctrl_r <= fitted_r ? `SPTX_RESET_FITTED : `SPTX_RESET_ABSENT;
               ctrl_init_r <= 1'b1;
            end
         end
         else if (!fitted_r)
         begin
            ctrl_r <= `SPTX_RESET_ABSENT;
         end
         else
         begin
            if (do_write && awaddr_r == `SPTX_OFF_CONTROL)
            begin
               // All fields are written; software keeps the enable clear meanwhile.
               ctrl_r <= ctrl_wr[15:0];
            end
            else if (!cfg_r[`SPTX_CFG_BIT_SLAVE])
            begin
               // Master mode: the rate follows the master selection.
               ctrl_r[`SPTX_RATE_HI:`SPTX_RATE_LO] <= master_rate_select[2:0];
            end
         end
      end
   end

   // Configuration register holding enable and slave mode.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cfg_r <= 32'h0000_0000;
      end
      else if (clk_en && do_write && awaddr_r == `SPTX_OFF_CONFIG)
      begin
         cfg_r <= sptx_merge(cfg_r, wdata_r, wstrb_r) & 32'h0000_0180;
      end
   end

   assign tx_enable = cfg_r[`SPTX_CFG_BIT_ENABLE] & fitted_r;

   //////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.
   //////////////////////////////////////////////////////////////////////////////////////////

   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] frame_cnt_r;

   assign s_axi_arready = ~rvalid_r;

   // Answers a read one cycle after the address is taken.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `SPTX_RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= sptx_mapped({s_axi_araddr[7:2], 2'b00}) ? `SPTX_RESP_OKAY
                                                               : `SPTX_RESP_SLVERR;
            case ({s_axi_araddr[7:2], 2'b00})
               `SPTX_OFF_CONTROL: rdata_r <= {16'h0000, ctrl_r};
               `SPTX_OFF_CONFIG: rdata_r <= cfg_r;
               `SPTX_OFF_STATUS: rdata_r <= {23'h00_0000, fitted_r, frame_cnt_r};
               default: rdata_r <= 32'h0000_0000;
            endcase
         end
         else if (s_axi_rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Channel status sequencer.
   //////////////////////////////////////////////////////////////////////////////////////////

   logic cs_sel;
   logic cs_bit_r;
   logic vbit_r;
   logic bstart_r;

   // Counts frames through the 192-frame block while enabled.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         frame_cnt_r <= 8'h00;
      end
      else if (clk_en)
      begin
         if (!tx_enable)
         begin
            frame_cnt_r <= 8'h00;
         end
         else if (frame_tick)
         begin
            frame_cnt_r <= (frame_cnt_r == `SPTX_BLOCK_FRAMES - 8'd1) ? 8'h00
                                                                      : frame_cnt_r + 8'd1;
         end
      end
   end

   // Picks the status bit for the current frame.
   sptx_cs_mux u_mux (
      .ctrl(ctrl_r),
      .frame(frame_cnt_r),
      .cs_bit(cs_sel)
   );

   // Registers the status bit and block start on each frame strobe while enabled, clearing them while disabled, and validity on every clock.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cs_bit_r <= 1'b0;
         vbit_r <= 1'b0;
         bstart_r <= 1'b0;
      end
      else if (clk_en)
      begin
         // Validity tracks bit 15 at once, for both subframes.
         vbit_r <= ctrl_r[`SPTX_BIT_VALIDITY] & tx_enable;
         if (frame_tick && tx_enable)
         begin
            cs_bit_r <= cs_sel;
            bstart_r <= (frame_cnt_r == 8'h00);
         end
         else if (!tx_enable)
         begin
            cs_bit_r <= 1'b0;
            bstart_r <= 1'b0;
         end
      end
   end

   assign cs_bit = cs_bit_r;
   assign validity_bit = vbit_r;
   assign block_start = bstart_r;
endmodule : sptx_control

// File: sptx_chk.sv
// Port assertions for the S/PDIF transmitter control block.
`timescale 1ns/1ps
module sptx_chk (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Strap and serialiser side.
   input wire logic transmitter_present_strap,
   input wire logic frame_tick,
   input wire logic validity_bit,
   input wire logic cs_bit,
   input wire logic block_start,
   input wire logic tx_enable
);
   logic [8:0] tick_cnt_r; // Ticks since the last block start.
   logic seen_r; // A block start has been seen.
   logic [2:0] strap_cnt_r; // Saturating count of strap-high cycles.
   // Counts frames per block and how long the strap has stood high.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tick_cnt_r <= 9'h000;
         seen_r <= 1'b0;
         strap_cnt_r <= 3'h0;
      end
      else
      begin
         tick_cnt_r <= $rose(block_start) ? {8'h00, frame_tick} : tick_cnt_r + {8'h00, frame_tick};
         // A disable restarts the block, so the first start after it is not measured.
         seen_r <= tx_enable & (seen_r | $rose(block_start));
         strap_cnt_r <= !transmitter_present_strap ? 3'h0 :
            (strap_cnt_r == 3'h7 ? 3'h7 : strap_cnt_r + 3'h1);
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped.");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped.");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read not answered.");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("Write taken with response pending.");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write not answered.");
   validity_gate_a: assert property (validity_bit |-> $past(tx_enable))
      else $error("Validity set while disabled.");
   status_hold_a: assert property (!frame_tick && tx_enable
      |=> $stable(cs_bit) && $stable(block_start))
      else $error("Status changed without a frame.");
   block_len_a: assert property ($rose(block_start) && seen_r |-> tick_cnt_r == 9'h0c0)
      else $error("Block length wrong.");
   strap_off_a: assert property (strap_cnt_r == 3'h7 |-> !tx_enable)
      else $error("Enabled without transmitter.");
endmodule : sptx_chk
bind sptx_control sptx_chk sptx_chk_i (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .transmitter_present_strap,
   .frame_tick, .validity_bit, .cs_bit, .block_start, .tx_enable);

// File: sptx_rx_model.sv
// Behavioural serialiser and receiver that paces frames and collects channel status.
`timescale 1ns/1ps
module sptx_rx_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Idle clocks between frame strobes.
   input wire logic [3:0] gap,
   // Per-frame signals from the block.
   input wire logic cs_bit,
   input wire logic block_start,
   // Frame strobe to the block.
   output logic frame_tick,
   // Collected status bits and count of complete blocks.
   output logic [191:0] cs_blk,
   output logic [7:0] blk_cnt
);
   logic [3:0] wait_r; // Clocks left before the next strobe.
   logic pend_r; // A strobe was taken; its bit shows now.
   logic [7:0] idx_r; // Next slot in the block.
   wire [7:0] slot = block_start ? 8'h00 : idx_r;
   // Issues strobes and files each status bit in its slot of the block.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wait_r <= 4'h0;
         pend_r <= 1'b0;
         idx_r <= 8'h00;
         frame_tick <= 1'b0;
         cs_blk <= '0;
         blk_cnt <= 8'h00;
      end
      else
      begin
         frame_tick <= (wait_r == 4'h0);
         wait_r <= (wait_r == 4'h0) ? gap : wait_r - 4'h1;
         pend_r <= frame_tick;
         if (pend_r)
         begin
            cs_blk[slot] <= cs_bit;
            idx_r <= slot + 8'h01;
            blk_cnt <= blk_cnt + {7'h00, slot == 8'hbf};
         end
      end
   end
endmodule : sptx_rx_model

// File: tb_top.sv
// Self-checking testbench for the S/PDIF transmitter control block.
`timescale 1ns/1ps
`include "sptx_params.svh"
module tb_top;
   logic clock, rst, clk_en, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, blk_cnt, b0;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
   logic [3:0] s_axi_wstrb, master_rate_select, gap;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic transmitter_present_strap, frame_tick, validity_bit, cs_bit, block_start, tx_enable;
   logic [191:0] cs_blk;
   logic [15:0] v;
   logic [2:0] rates [5];
   int err_total, n_tests, cyc, n;
   sptx_control sptx_control_i (.clock, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .transmitter_present_strap,
      .master_rate_select, .frame_tick, .validity_bit, .cs_bit, .block_start, .tx_enable);
   sptx_rx_model sptx_rx_model_i (.clock, .rst, .gap, .cs_bit, .block_start, .frame_tick,
      .cs_blk, .blk_cnt);
   always #50 clock = ~clock;
   // Expected status bits 39:0 for a control value.
   function automatic logic [39:0] exp_cs(input logic [15:0] c);
      logic [39:0] e;
      e = '0;
      if (c[0])
      begin
         e[7:0] = {c[13:12], 3'h0, c[3], c[1], 1'b1};
         e[38:35] = {1'b0, c[14:12]};
      end
      else
      begin
         e[15:0] = {c[11:4], 4'h0, c[3:1], 1'b0};
         e[27:24] = {1'b0, c[14:12]};
      end
      return e;
   endfunction : exp_cs
   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : check
   // One bus write; both channels offered together, each released when taken.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_t, w_t, b_t;
      int k;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      b_t = 1'b0;
      for (k = 0; k < 50 && !b_t; k++)
      begin
         #1;
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (aw_t)
            s_axi_awvalid <= 1'b0;
         if (w_t)
            s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      err_total += int'(!b_t);
   endtask : axi_wr
   // One bus read; the address is released when taken, and ready is held until the answer is sampled.
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_t, r_t;
      int k;
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      r_t = 1'b0;
      for (k = 0; k < 50 && !r_t; k++)
      begin
         #1;
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (ar_t)
            s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      err_total += int'(!r_t);
   endtask : axi_rd
   // Resets the block with the strap at a given level.
   task automatic do_reset(input logic s);
      transmitter_present_strap <= s;
      rst <= 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : do_reset
   // Prints counts and verdict, then ends the run.
   task automatic finish_test();
      $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // Cuts a hang short.
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         finish_test();
      end
   end
   initial
   begin
      seed = 32'h3781_6ace;
      rates = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
      {clock, rst, clk_en, transmitter_present_strap} = 4'h6;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0000_0000_0000, 4'hf};
      {master_rate_select, gap} = 8'h22;
      do_reset(1'b0);
      axi_rd(`SPTX_OFF_CONTROL, rd, rs);
      check({8'h00, rd}, {24'h00_0000, `SPTX_RESET_FITTED});
      axi_rd(8'h10, rd, rs);
      check({6'h00, rs, rd}, {6'h00, `SPTX_RESP_SLVERR, 32'h0000_0000});
      $display("test reset done");
      repeat (3)
      begin
         v[14:12] = rates[$unsigned($random(seed)) % 5];
         master_rate_select <= {1'b0, v[14:12]};
         repeat (3) @(posedge clock);
         axi_rd(`SPTX_OFF_CONTROL, rd, rs);
         check({37'h0, rd[14:12]}, {37'h0, v[14:12]});
      end
      axi_wr(`SPTX_OFF_CONFIG, 32'h0000_0100, rs);
      for (int i = 0; i < 5; i++)
      begin
         v = {1'b0, rates[i], 12'($random(seed))};
         axi_wr(`SPTX_OFF_CONTROL, {16'h0000, v}, rs);
         axi_rd(`SPTX_OFF_CONTROL, rd, rs);
         check({6'h00, rs, rd}, {6'h00, `SPTX_RESP_OKAY, 16'h0000, v});
      end
      $display("test rate done");
      for (int p = 0; p < 2; p++)
      begin
         gap <= p[0] ? 4'h7 : 4'h2;
         v = {1'b0, rates[$unsigned($random(seed)) % 5], 11'($random(seed)), p[0]};
         axi_wr(`SPTX_OFF_CONTROL, {16'h0000, v}, rs);
         axi_wr(`SPTX_OFF_CONFIG, 32'h0000_0180, rs);
         b0 = blk_cnt;
         for (n = 0; n < 4000 && 8'(blk_cnt - b0) < 8'h02; n++)
            @(posedge clock);
         rd = p[0] ? 32'h0000_00c7 : 32'h0f00_ff0f;
         check(cs_blk[39:0] & {p[0] ? 8'h78 : 8'h00, rd}, exp_cs(v) & {p[0] ? 8'h78 : 8'h00, rd});
         check({39'h0, validity_bit}, 40'h0);
         axi_wr(`SPTX_OFF_CONFIG, 32'h0000_0100, rs);
      end
      $display("test status done");
      axi_wr(`SPTX_OFF_CONFIG, 32'h0000_0180, rs);
      axi_wr(`SPTX_OFF_CONTROL, {16'h0000, v | 16'h8000}, rs);
      repeat (2) @(posedge clock);
      check({39'h0, validity_bit}, 40'h1);
      axi_wr(`SPTX_OFF_CONTROL, {16'h0000, v}, rs);
      repeat (2) @(posedge clock);
      check({39'h0, validity_bit}, 40'h0);
      axi_wr(8'h10, 32'h0000_0000, rs);
      check({38'h0, rs}, {38'h0, `SPTX_RESP_SLVERR});
      $display("test validity done");
      do_reset(1'b1);
      axi_wr(`SPTX_OFF_CONTROL, 32'h0000_5555, rs);
      axi_wr(`SPTX_OFF_CONFIG, 32'h0000_0080, rs);
      axi_rd(`SPTX_OFF_CONTROL, rd, rs);
      check({8'h00, rd}, {24'h00_0000, `SPTX_RESET_ABSENT});
      check({39'h0, tx_enable}, 40'h0);
      $display("test absent done");
      finish_test();
   end
endmodule : tb_top
